/* File: design/hbh_handover.sv */
// Host bus handover arbiter with host register-access ready generation.
`timescale 1ns/1ps
`include "hbh_params.svh"

module hbh_handover #(
  parameter int PEERS = `HBH_PEER_COUNT,
  parameter int WAITS = `HBH_WAIT_STATES
) (
  input  wire logic             clk,                 // Input clock.
  input  wire logic             sys_rst,             // Sync reset, high.
  input  wire logic             clk_en,              // Freezes all state.
  input  wire logic             host_bus_request_n,  // Host request pin.
  input  wire logic             chip_select_n,       // Host select pin.
  input  wire logic [PEERS-1:0] peer_bus_requests_n, // Peer request pins.
  input  wire logic [PEERS-1:0] own_request_sel,     // One-hot own line.
  input  wire logic             own_request,         // Core wants the bus.
  input  wire logic             host_grant_pin_n,    // Grant pin level.
  output logic                  host_bus_grant_val,  // Grant drive value.
  output logic                  host_bus_grant_oe_n, // Low drives grant.
  output logic                  bus_release,         // Bus lines tristated.
  output logic                  is_master,           // This part owns bus.
  output logic                  own_bus_request_n,   // Own request drive.
  output logic                  host_access_ready_val, // Ready drive value.
  output logic                  host_access_ready_oe_n, // Low drives ready.
  output logic                  host_grant_seen      // Grant monitored.
);

  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  logic [2:0] hbr_sync_ff;
  logic [2:0] cs_sync_ff;
  logic [2:0] hbg_sync_ff;
  logic [PEERS-1:0] peer_s1_ff, peer_s2_ff, peer_s3_ff;
  logic hbr_q_ff, cs_q_ff, hbg_q_ff;
  logic [PEERS-1:0] peer_q_ff;

  // Three flops each; a change counts once stages two and three agree.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hbr_sync_ff <= 3'h7;
      cs_sync_ff  <= 3'h7;
      hbg_sync_ff <= 3'h7;
      peer_s1_ff  <= '1;
      peer_s2_ff  <= '1;
      peer_s3_ff  <= '1;
    end else if (clk_en) begin
      hbr_sync_ff <= {hbr_sync_ff[1:0], host_bus_request_n};
      cs_sync_ff  <= {cs_sync_ff[1:0], chip_select_n};
      hbg_sync_ff <= {hbg_sync_ff[1:0], host_grant_pin_n};
      peer_s1_ff  <= peer_bus_requests_n;
      peer_s2_ff  <= peer_s1_ff;
      peer_s3_ff  <= peer_s2_ff;
    end
  end

  // Filtered levels: update only when the last two stages agree.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hbr_q_ff  <= 1'b1;
      cs_q_ff   <= 1'b1;
      hbg_q_ff  <= 1'b1;
      peer_q_ff <= '1;
    end else if (clk_en) begin
      if (hbr_sync_ff[1] == hbr_sync_ff[2]) hbr_q_ff <= hbr_sync_ff[2];
      if (cs_sync_ff[1] == cs_sync_ff[2]) cs_q_ff <= cs_sync_ff[2];
      if (hbg_sync_ff[1] == hbg_sync_ff[2]) hbg_q_ff <= hbg_sync_ff[2];
      peer_q_ff <= (peer_s2_ff & peer_s3_ff) |
                   (peer_q_ff & (peer_s2_ff ^ peer_s3_ff));
    end
  end

  //--------------------------------------------------------------------
  // Arbitration
  //--------------------------------------------------------------------
  wire host_req    = ~hbr_q_ff;
  wire host_sel    = ~cs_q_ff;
  wire peer_others = |(~peer_q_ff & ~own_request_sel);
  // The host outranks every peer, so a host win needs no peer check.
  wire host_wins   = host_req;
  wire take_bus    = own_request & ~host_req & ~peer_others;

  hbh_pkg::hbh_state_type state_ff, nxt_state;
  logic master_ff, nxt_master;
  logic [7:0] float_cnt_ff;

  // Grant path: float for a clock, grant, hold until request drops.
  always_comb begin
    nxt_state  = state_ff;
    nxt_master = master_ff;
    unique case (state_ff)
      hbh_pkg::HBH_IDLE: begin
        if (take_bus) begin
          nxt_state  = hbh_pkg::HBH_OWN;
          nxt_master = 1'b1;
        end
      end
      hbh_pkg::HBH_OWN: begin
        if (host_wins) nxt_state = hbh_pkg::HBH_FLOAT;
      end
      hbh_pkg::HBH_FLOAT: begin
        if (!host_req) nxt_state = hbh_pkg::HBH_OWN;
        else if (float_cnt_ff >= 8'(`HBH_FLOAT_CYC - 1))
          nxt_state = hbh_pkg::HBH_GRANT;
      end
      hbh_pkg::HBH_GRANT: begin
        if (!host_req) nxt_state = hbh_pkg::HBH_OWN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff     <= hbh_pkg::HBH_IDLE;
      master_ff    <= 1'b0;
      float_cnt_ff <= 8'h00;
    end else if (clk_en) begin
      state_ff     <= nxt_state;
      master_ff    <= nxt_master;
      float_cnt_ff <= (state_ff == hbh_pkg::HBH_FLOAT) ?
                      float_cnt_ff + 8'h01 : 8'h00;
    end
  end

  //--------------------------------------------------------------------
  // Output registers
  //--------------------------------------------------------------------
  wire nxt_grant_drive = master_ff & (nxt_state == hbh_pkg::HBH_GRANT);
  wire nxt_release     = nxt_state == hbh_pkg::HBH_FLOAT ||
                         nxt_state == hbh_pkg::HBH_GRANT ||
                         nxt_state == hbh_pkg::HBH_IDLE;
  // Non-masters only monitor the grant line; they never drive it.
  wire nxt_grant_oe_n  = ~nxt_grant_drive;

  logic [7:0] wait_cnt_ff;
  wire access   = host_sel & host_req;
  wire nxt_wait = access & (wait_cnt_ff < 8'(WAITS));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_bus_grant_val     <= 1'b1;
      host_bus_grant_oe_n    <= 1'b1;
      bus_release            <= 1'b1;
      is_master              <= 1'b0;
      own_bus_request_n      <= 1'b1;
      host_access_ready_val  <= 1'b1;
      host_access_ready_oe_n <= 1'b1;
      host_grant_seen        <= 1'b0;
      wait_cnt_ff            <= 8'h00;
    end else if (clk_en) begin
      host_bus_grant_val     <= 1'b0;
      host_bus_grant_oe_n    <= nxt_grant_oe_n;
      bus_release            <= nxt_release;
      is_master              <= nxt_master;
      own_bus_request_n      <= ~(own_request & ~nxt_master);
      // Open drain: drive low only while a wait state is inserted.
      host_access_ready_val  <= 1'b0;
      host_access_ready_oe_n <= ~nxt_wait;
      host_grant_seen        <= ~hbg_q_ff;
      wait_cnt_ff <= access ? (nxt_wait ? wait_cnt_ff + 8'h01 : wait_cnt_ff)
                            : 8'h00;
    end
  end

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  sequence float_then_grant;
    host_bus_grant_oe_n ##1 !host_bus_grant_oe_n;
  endsequence

  grant_held_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clk_en && !host_bus_grant_oe_n && host_req) |=> !host_bus_grant_oe_n)
    else $error("Grant dropped while host still requests.");

  grant_after_release_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !host_bus_grant_oe_n |-> bus_release)
    else $error("Grant issued while bus still driven.");

  grant_floats_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(host_bus_grant_oe_n) |-> $past(bus_release))
    else $error("Grant issued without a float cycle.");

  grant_master_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !host_bus_grant_oe_n |-> is_master)
    else $error("Non-master drives grant line.");

  host_first_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clk_en && host_req && state_ff == hbh_pkg::HBH_IDLE) |=> !is_master)
    else $error("Peer side took bus over host request.");

  ready_wait_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !host_access_ready_oe_n |-> $past(access))
    else $error("Ready pulled low outside host access.");

  grant_seq_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clk_en && state_ff == hbh_pkg::HBH_OWN && host_req) |=>
      float_then_grant or !clk_en or !host_req)
    else $error("Float-then-grant sequence broken.");

  ready_bound_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wait_cnt_ff <= 8'(WAITS))
    else $error("Too many wait states inserted.");

  // The grant may only let go once the synced request has gone away.
  grant_release_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(host_bus_grant_oe_n) |-> !$past(host_req))
    else $error("Grant released while host still requests.");

endmodule

/* File: inc/hbh_params.svh */
// Timing and field constants for the host bus handover block.
`ifndef HBH_PARAMS_SVH
`define HBH_PARAMS_SVH
`define HBH_CLK_PERIOD_NS   40
`define HBH_FLOAT_NS        40
`define HBH_FLOAT_CYC       \
  ((`HBH_FLOAT_NS + `HBH_CLK_PERIOD_NS - 1) / `HBH_CLK_PERIOD_NS)
`define HBH_PEER_COUNT      6
`define HBH_WAIT_STATES     2
`endif

/* File: inc/hbh_pkg.sv */
// Types shared by the host bus handover block.
package hbh_pkg;
  typedef enum logic [1:0] {
    HBH_OWN   = 2'h0,
    HBH_FLOAT = 2'h1,
    HBH_GRANT = 2'h3,
    HBH_IDLE  = 2'h2
  } hbh_state_type;
endpackage

/* File: sim/hbh_host_model.sv */
// Behavioural host that requests the bus and makes register accesses.
`timescale 1ns/1ps
module hbh_host_model (
  input  wire logic clk,       // Input clock.
  input  wire logic want_bus,  // Bench asks for the bus.
  input  wire logic want_acc,  // Bench asks for an access.
  input  wire logic ready_pin, // Resolved ready wire.
  output logic      hbr_n,     // Host request pin.
  output logic      cs_n,      // Host select pin.
  output logic      acc_done   // Access finished.
);
  logic [3:0] age_ff;
  // Pins start released, as the pull-ups leave them.
  initial begin
    hbr_n = 1'b1;
    cs_n = 1'b1;
    acc_done = 1'b0;
    age_ff = 4'h0;
  end
  // Accesses last eight cycles at least, as ready lags the synchronisers.
  always @(posedge clk) begin
    hbr_n <= ~want_bus;
    cs_n <= ~(want_acc && !acc_done);
    age_ff <= cs_n ? 4'h0 : age_ff + 4'h1;
    acc_done <= want_acc && (acc_done ||
                (!cs_n && age_ff > 4'h7 && ready_pin));
  end
endmodule

/* File: sim/hbh_handover_tb.sv */
// Self-checking bench for the host bus handover arbiter.
`timescale 1ns/1ps
`include "hbh_params.svh"
module hbh_handover_tb;
  logic clk, sys_rst, own_req, other_n, want_bus, want_acc;
  logic [`HBH_PEER_COUNT-1:0] peers_n;
  logic en;
  logic hbr_n, cs_n, done, g_o, g_oe_n, rel, mst, preq_n, r_o, r_oe_n, seen;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int low_cnt = 0;
  int base;
  // Grant idles high by its pull-up; ready is open drain with a pull-up.
  wire grant_pin = g_oe_n ? other_n : g_o;
  wire ready_pin = r_oe_n ? 1'b1 : r_o;
  hbh_handover dut (.clk(clk), .sys_rst(sys_rst), .clk_en(en),
    .host_bus_request_n(hbr_n), .chip_select_n(cs_n),
    .peer_bus_requests_n(peers_n), .own_request_sel(6'h01),
    .own_request(own_req), .host_grant_pin_n(grant_pin),
    .host_bus_grant_val(g_o), .host_bus_grant_oe_n(g_oe_n),
    .bus_release(rel), .is_master(mst), .own_bus_request_n(preq_n),
    .host_access_ready_val(r_o), .host_access_ready_oe_n(r_oe_n),
    .host_grant_seen(seen));
  hbh_host_model host (.clk(clk), .want_bus(want_bus), .want_acc(want_acc),
    .ready_pin(ready_pin), .hbr_n(hbr_n), .cs_n(cs_n), .acc_done(done));
  // Free-running clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Wait states are counted here; the ceiling cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (r_oe_n === 1'b0) low_cnt <= low_cnt + 1;
    if (cyc == 4000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge clk) #1;
  endtask
  task automatic conclude;
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // A non-master must leave the grant undriven but still watch it.
  task automatic s_nonmaster;
    @(posedge clk) want_bus <= 1'b1;
    repeat (12) begin
      tick();
      chk("grant_oe_n", 8'h01, g_oe_n);
    end
    @(posedge clk) other_n <= 1'b0;
    own_req <= 1'b1;
    repeat (6) tick();
    chk("seen", 8'h01, seen);
    chk("host_first", 8'h00, mst);
    chk("own_request_n", 8'h00, preq_n);
    @(posedge clk) other_n <= 1'b1;
    want_bus <= 1'b0;
    own_req <= 1'b0;
    repeat (8) tick();
  endtask
  // A select without a bus request must not stretch the access.
  task automatic s_nohost;
    base = low_cnt;
    @(posedge clk) want_acc <= 1'b1;
    for (int i = 0; i < 30 && done !== 1'b1; i++) tick();
    chk("waits", 8'h00, 8'(low_cnt - base));
    @(posedge clk) want_acc <= 1'b0;
    tick();
  endtask
  // Master hands over with a peer also asking, then takes an access.
  task automatic s_handover;
    @(posedge clk) peers_n <= 6'h3D;
    repeat (6) tick();
    @(posedge clk) own_req <= 1'b1;
    repeat (4) tick();
    chk("peer_first", 8'h00, mst);
    chk("own_request_n", 8'h00, preq_n);
    @(posedge clk) peers_n <= 6'h3F;
    for (int i = 0; i < 10 && mst !== 1'b1; i++) tick();
    chk("release", 8'h00, rel);
    chk("own_request_n", 8'h01, preq_n);
    @(posedge clk) peers_n <= 6'h3D;
    want_bus <= 1'b1;
    for (int i = 0; i < 12 && rel !== 1'b1; i++) tick();
    chk("release", 8'h01, rel);
    chk("float", 8'h01, g_oe_n);
    tick();
    chk("grant", 8'h00, grant_pin);
    base = low_cnt;
    @(posedge clk) want_acc <= 1'b1;
    for (int i = 0; i < 30 && done !== 1'b1; i++) begin
      tick();
      chk("grant_oe_n", 8'h00, g_oe_n);
    end
    chk("done", 8'h01, done);
    chk("waits", 8'(`HBH_WAIT_STATES), 8'(low_cnt - base));
    @(posedge clk) want_acc <= 1'b0;
    want_bus <= 1'b0;
    peers_n <= 6'h3F;
    for (int i = 0; i < 10 && g_oe_n !== 1'b1; i++) tick();
    chk("grant_oe_n", 8'h01, g_oe_n);
    tick();
    chk("release", 8'h00, rel);
  endtask
  // A low clock enable holds off the handover until it returns.
  task automatic s_freeze;
    @(posedge clk) en <= 1'b0;
    want_bus <= 1'b1;
    repeat (10) tick();
    chk("frozen_release", 8'h00, rel);
    chk("frozen_grant_oe_n", 8'h01, g_oe_n);
    @(posedge clk) en <= 1'b1;
    for (int i = 0; i < 12 && g_oe_n !== 1'b0; i++) tick();
    chk("grant_oe_n", 8'h00, g_oe_n);
    chk("release", 8'h01, rel);
    @(posedge clk) want_bus <= 1'b0;
    for (int i = 0; i < 10 && g_oe_n !== 1'b1; i++) tick();
    chk("grant_oe_n", 8'h01, g_oe_n);
  endtask
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    sys_rst = 1'b1;
    en = 1'b1;
    own_req = 1'b0;
    other_n = 1'b1;
    want_bus = 1'b0;
    want_acc = 1'b0;
    peers_n = 6'h3F;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) tick();
    s_nonmaster();
    s_nohost();
    s_handover();
    s_freeze();
    conclude();
  end
endmodule
